// [rtl/enc_pkg.sv]
// constants, register map and types for the incremental speed sensor evaluator
package enc_pkg;

    // clock and measurement window
    localparam int CLK_MHZ = 250;
    localparam int WINDOW_US = 1000;
    localparam int WINDOW_CYC = WINDOW_US * CLK_MHZ;
    // speed unit is 0.01 rpm: edges per window * 60 s/min * 1e6/WINDOW_US * 100
    localparam logic [22:0] SPEED_SCALE = 23'(64'd6000000000 / 64'(WINDOW_US));

    // register byte offsets
    localparam logic [7:0] OFF_MODE = 8'h00;
    localparam logic [7:0] OFF_MARKS = 8'h04;
    localparam logic [7:0] OFF_GEAR_NUM = 8'h08;
    localparam logic [7:0] OFF_GEAR_DEN = 8'h0c;
    localparam logic [7:0] OFF_FILT_TC = 8'h10;
    localparam logic [7:0] OFF_DRIVE_CFG = 8'h14;
    localparam logic [7:0] OFF_STATUS = 8'h18;
    localparam logic [7:0] OFF_SPEED = 8'h1c;
    localparam logic [7:0] OFF_RAW_SPEED = 8'h20;
    localparam logic [7:0] OFF_POSITION = 8'h24;

    // status fields
    localparam int ST_FAULT = 0;
    localparam int ST_SEEN = 1;
    localparam int ST_DIR = 2;

    // reset values and ranges
    localparam logic [15:0] MODE_RST = 16'h0000;
    localparam logic [13:0] MARKS_RST = 14'd1024;
    localparam logic [13:0] MARKS_MIN = 14'd1;
    localparam logic [13:0] MARKS_MAX = 14'd8192;
    localparam logic signed [15:0] GEAR_NUM_RST = 16'sd100;
    localparam logic signed [15:0] GEAR_NUM_MAX = 16'sd30000;
    localparam logic [15:0] GEAR_DEN_RST = 16'd100;
    localparam logic [15:0] GEAR_DEN_MIN = 16'd1;
    localparam logic [15:0] GEAR_DEN_MAX = 16'd30000;
    localparam logic [14:0] FILT_TC_RST = 15'd0;
    localparam logic [14:0] FILT_TC_MAX = 15'd32000;
    localparam logic [15:0] DRIVE_CFG_RST = 16'd0;

    // drive configurations that hand track b to the sensor by default
    localparam logic [15:0] CFG_A = 16'd210;
    localparam logic [15:0] CFG_B = 16'd211;
    localparam logic [15:0] CFG_C = 16'd230;

    // divider length
    localparam logic [6:0] DIV_STEPS = 7'd64;

    typedef enum logic [1:0] {
        CH_OFF = 2'b00,
        CH_QUAD = 2'b01,
        CH_UNSIGNED = 2'b10,
        CH_DIRPIN = 2'b11
    } chan_t;

    typedef enum logic [1:0] {
        CALC_IDLE = 2'b00,
        CALC_SPEED = 2'b01,
        CALC_FILT = 2'b10
    } calc_t;

endpackage : enc_pkg

// [rtl/incremental_encoder_speed_eval.sv]
// speed sensor evaluation: track decoding, index check, speed, gear, filter, apb registers
//
// Contract
// - modes 1001/1002/1004 decode a and b with direction, index on the index input, 1/2/4 edges.
// - modes 1011/1012 use track a only, positive speed, 1/2 edges, index used, track b freed.
// - modes 1031/1032 count track a 1/2 edges, index used, direction input low positive.
// - modes 1101/1102/1104 act as 1001/1002/1004 with the speed negated.
// - modes 1111/1112 act as 1011/1012 with the speed negative.
// - modes 1131/1132 count track a 1/2 edges, index used, direction input low negative.
// - drive configurations 210, 211 and 230 assign track b to the sensor by default.
// - unsigned modes 11 and 12 leave track b free for other functions.
// - the division mark count is 1 to 8192, 1024 after reset, and converts edges to speed.
// - speed is scaled by numerator -300.00..300.00 over denominator 0.01..300.00, both 1.00.
// - speed is low-pass filtered with a 0 to 32000 us time constant, 0 meaning none.
// - edge rates up to 150 kHz on tracks a and b are counted without loss.
// - in index modes the index spacing is checked against the mark count and faults flagged.
// - mode 0 stops measurement and frees the track inputs.
//
// The APB register port and the address map were chosen for this implementation.
`timescale 1ns/1ps

module incremental_encoder_speed_eval
    import enc_pkg::*;
#(
    parameter int WINDOW_CYCLES = enc_pkg::WINDOW_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // sensor pins
    input wire logic track_a_input,
    input wire logic track_b_or_direction_input,
    input wire logic index_track_input,
    // results
    output logic signed [31:0] speed_out,
    output logic index_mark_pulse,
    output logic index_fault,
    output logic track_a_free,
    output logic track_b_free,
    output logic track_b_assigned
);
    import enc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////////////////
    // registers and mode decode

    logic [15:0] mode_r;
    logic [13:0] marks_r;
    logic signed [15:0] gear_num_r;
    logic [15:0] gear_den_r;
    logic [14:0] filt_tc_r;
    logic [15:0] drive_cfg_r;
    logic fault_r;
    logic seen_r;
    logic dir_r;
    logic signed [31:0] raw_r;
    logic signed [31:0] filt_r;
    logic signed [31:0] pos_r;
    logic [31:0] prdata_r;

    chan_t chan;
    logic [2:0] eval;
    logic invert;
    logic ref_mode;

    always_comb begin
        chan = CH_OFF;
        eval = 3'd1;
        invert = 1'b0;
        ref_mode = 1'b1;
        unique case (mode_r)
            16'd1001: chan = CH_QUAD;
            16'd1002: begin chan = CH_QUAD; eval = 3'd2; end
            16'd1004: begin chan = CH_QUAD; eval = 3'd4; end
            16'd1011: chan = CH_UNSIGNED;
            16'd1012: begin chan = CH_UNSIGNED; eval = 3'd2; end
            16'd1031: chan = CH_DIRPIN;
            16'd1032: begin chan = CH_DIRPIN; eval = 3'd2; end
            16'd1101: begin chan = CH_QUAD; invert = 1'b1; end
            16'd1102: begin chan = CH_QUAD; eval = 3'd2; invert = 1'b1; end
            16'd1104: begin chan = CH_QUAD; eval = 3'd4; invert = 1'b1; end
            16'd1111: begin chan = CH_UNSIGNED; invert = 1'b1; end
            16'd1112: begin chan = CH_UNSIGNED; eval = 3'd2; invert = 1'b1; end
            16'd1131: begin chan = CH_DIRPIN; invert = 1'b1; end
            16'd1132: begin chan = CH_DIRPIN; eval = 3'd2; invert = 1'b1; end
            16'd11: begin chan = CH_UNSIGNED; ref_mode = 1'b0; end
            16'd12: begin chan = CH_UNSIGNED; eval = 3'd2; ref_mode = 1'b0; end
            default: begin chan = CH_OFF; ref_mode = 1'b0; end
        endcase
    end

    // track b belongs to the sensor only when the mode reads it
    logic uses_b;
    logic cfg_default_b;
    assign uses_b = (chan == CH_QUAD) || (chan == CH_DIRPIN);
    assign cfg_default_b = (drive_cfg_r == CFG_A) || (drive_cfg_r == CFG_B)
        || (drive_cfg_r == CFG_C);

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            track_a_free <= 1'b1;
            track_b_free <= 1'b1;
            track_b_assigned <= 1'b0;
        end else begin
            track_a_free <= (chan == CH_OFF);
            track_b_free <= !uses_b;
            track_b_assigned <= cfg_default_b && (chan == CH_OFF || uses_b);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////
    // input synchronisers and edge detection

    logic [2:0] pin_m;
    logic [2:0] pin_s;
    logic [2:0] pin_d;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pin_m <= 3'h0;
            pin_s <= 3'h0;
            pin_d <= 3'h0;
        end else begin
            pin_m <= {index_track_input, track_b_or_direction_input, track_a_input};
            pin_s <= pin_m;
            pin_d <= pin_s;
        end
    end

    logic a_s, b_s, a_d, b_d, a_rise, a_chg, b_chg, z_rise;
    assign a_s = pin_s[0];
    assign b_s = pin_s[1];
    assign a_d = pin_d[0];
    assign b_d = pin_d[1];
    assign a_rise = a_s & ~a_d;
    assign a_chg = a_s ^ a_d;
    assign b_chg = b_s ^ b_d;
    assign z_rise = pin_s[2] & ~pin_d[2];

    // one step per clock at most; 250 MHz leaves wide margin over 150 kHz edges
    logic step;
    logic step_up;

    always_comb begin
        step = 1'b0;
        step_up = 1'b1;
        unique case (chan)
            CH_QUAD: begin
                if (eval == 3'd1) begin
                    step = a_rise;
                    step_up = ~b_s;
                end else if (eval == 3'd2) begin
                    step = a_chg;
                    step_up = a_s ^ b_s;
                end else begin
                    // both tracks moving at once is an illegal gray step and is skipped
                    step = a_chg ^ b_chg;
                    step_up = b_d ^ a_s;
                end
            end
            CH_UNSIGNED, CH_DIRPIN: begin
                step = (eval == 3'd1) ? a_rise : a_chg;
            end
            CH_OFF: step = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////////////////
    // window counting, position and index check

    logic [31:0] win_cnt_r;
    logic win_end;
    logic signed [20:0] win_edges_r;
    logic signed [20:0] sample_r;
    logic signed [23:0] idx_delta_r;
    logic [16:0] expected;
    logic [23:0] idx_mag;

    assign win_end = (win_cnt_r == 32'(WINDOW_CYCLES - 1));
    // widen before the product: 8192 marks times 4 edges overflows the mark field
    assign expected = 17'(marks_r) * 17'(eval);
    assign idx_mag = idx_delta_r[23] ? 24'(-idx_delta_r) : 24'(idx_delta_r);

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            win_cnt_r <= 32'h0;
            win_edges_r <= 21'sh0;
            sample_r <= 21'sh0;
        end else begin
            win_cnt_r <= win_end ? 32'h0 : win_cnt_r + 32'h1;
            if (win_end) begin
                sample_r <= win_edges_r;
                win_edges_r <= step ? (step_up ? 21'sd1 : -21'sd1) : 21'sh0;
            end else if (step) begin
                win_edges_r <= step_up ? win_edges_r + 21'sd1 : win_edges_r - 21'sd1;
            end
        end
    end

    logic fault_clr;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pos_r <= 32'sh0;
            idx_delta_r <= 24'sh0;
            seen_r <= 1'b0;
            fault_r <= 1'b0;
            index_mark_pulse <= 1'b0;
            dir_r <= 1'b0;
        end else begin
            if (step) begin
                pos_r <= step_up ? pos_r + 32'sd1 : pos_r - 32'sd1;
                dir_r <= ~step_up;
            end
            index_mark_pulse <= z_rise && ref_mode;
            if (!ref_mode) begin
                seen_r <= 1'b0;
                idx_delta_r <= 24'sh0;
            end else if (z_rise) begin
                seen_r <= 1'b1;
                // an edge arriving with the index opens the new turn, else one is lost
                idx_delta_r <= step ? (step_up ? 24'sd1 : -24'sd1) : 24'sh0;
            end else if (step) begin
                idx_delta_r <= step_up ? idx_delta_r + 24'sd1 : idx_delta_r - 24'sd1;
            end
            // a new fault in the clearing cycle wins over the clear
            if (ref_mode && z_rise && seen_r && idx_mag != 24'(expected)) begin
                fault_r <= 1'b1;
            end else if (fault_clr) begin
                fault_r <= 1'b0;
            end
        end
    end

    assign index_fault = fault_r;

    ////////////////////////////////////////////////////////////////////////////////////////////
    // speed conversion and filter, one shared serial divider

    calc_t calc_r;
    logic [63:0] divd_r;
    logic [31:0] dvsr_r;
    logic [32:0] rem_r;
    logic [6:0] cnt_r;
    logic neg_r;

    logic [32:0] rem_sh;
    logic rem_ge;
    logic [20:0] mag;
    logic [15:0] num_mag;
    logic samp_neg;
    logic signed [32:0] diff;
    logic [31:0] diff_mag;
    logic [31:0] quo_sat;

    assign rem_sh = {rem_r[31:0], divd_r[63]};
    assign rem_ge = rem_sh >= {1'b0, dvsr_r};
    assign mag = sample_r[20] ? 21'(-sample_r) : 21'(sample_r);
    assign num_mag = gear_num_r[15] ? 16'(-gear_num_r) : 16'(gear_num_r);
    // quad modes take the sign from the count, pin modes from the direction input
    assign samp_neg = ((chan == CH_QUAD) && sample_r[20])
        ^ ((chan == CH_DIRPIN) && b_s)
        ^ invert
        ^ gear_num_r[15];
    assign quo_sat = (divd_r[63:31] != 33'h0) ? 32'h7fffffff : divd_r[31:0];
    assign diff = 33'(raw_r) - 33'(filt_r);
    assign diff_mag = diff[32] ? 32'(-diff) : 32'(diff);

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            calc_r <= CALC_IDLE;
            divd_r <= 64'h0;
            dvsr_r <= 32'h1;
            rem_r <= 33'h0;
            cnt_r <= 7'h0;
            neg_r <= 1'b0;
            raw_r <= 32'sh0;
            filt_r <= 32'sh0;
        end else begin
            unique case (calc_r)
                CALC_IDLE: begin
                    if (win_end && chan == CH_OFF) begin
                        raw_r <= 32'sh0;
                        filt_r <= 32'sh0;
                    end else if (win_end) begin
                        // edges / (marks * eval) turns, times num / den
                        divd_r <= 64'(mag) * 64'(SPEED_SCALE) * 64'(num_mag);
                        dvsr_r <= 32'(marks_r) * 32'(eval) * 32'(gear_den_r);
                        neg_r <= samp_neg;
                        rem_r <= 33'h0;
                        cnt_r <= 7'h0;
                        calc_r <= CALC_SPEED;
                    end
                end
                CALC_SPEED, CALC_FILT: begin
                    if (cnt_r != DIV_STEPS) begin
                        rem_r <= rem_ge ? rem_sh - {1'b0, dvsr_r} : rem_sh;
                        divd_r <= {divd_r[62:0], rem_ge};
                        cnt_r <= cnt_r + 7'h1;
                    end else if (calc_r == CALC_SPEED) begin
                        raw_r <= neg_r ? -$signed(quo_sat) : $signed(quo_sat);
                        if (filt_tc_r <= 15'(WINDOW_US)) begin
                            filt_r <= neg_r ? -$signed(quo_sat) : $signed(quo_sat);
                            calc_r <= CALC_IDLE;
                        end else begin
                            calc_r <= CALC_FILT;
                        end
                    end else begin
                        // first-order step: y += (x - y) * window / tc
                        filt_r <= diff[32] ? filt_r - $signed(divd_r[31:0])
                            : filt_r + $signed(divd_r[31:0]);
                        calc_r <= CALC_IDLE;
                    end
                    if (calc_r == CALC_SPEED && cnt_r == DIV_STEPS
                        && filt_tc_r > 15'(WINDOW_US)) begin
                        divd_r <= 64'((neg_r ? diff_mag : diff_mag)) * 64'(WINDOW_US);
                        dvsr_r <= 32'(filt_tc_r);
                        rem_r <= 33'h0;
                        cnt_r <= 7'h0;
                    end
                end
                default: calc_r <= CALC_IDLE;
            endcase
        end
    end

    assign speed_out = filt_r;

    ////////////////////////////////////////////////////////////////////////////////////////////
    // apb slave: read data latched in setup, zero-wait access

    logic setup;
    logic access;
    logic wr;
    logic bad_addr;
    logic bad_val;
    logic [31:0] rd_mux;

    assign setup = psel && !penable;
    assign access = psel && penable;
    assign wr = access && pwrite && !pslverr;
    assign pready = access;
    assign prdata = prdata_r;
    assign fault_clr = wr && (paddr == OFF_STATUS) && pwdata[ST_FAULT];

    always_comb begin
        bad_addr = 1'b0;
        bad_val = 1'b0;
        rd_mux = 32'h0;
        unique case (paddr)
            OFF_MODE: rd_mux = {16'h0, mode_r};
            OFF_MARKS: begin
                rd_mux = {18'h0, marks_r};
                bad_val = pwdata > 32'(MARKS_MAX) || pwdata < 32'(MARKS_MIN);
            end
            OFF_GEAR_NUM: begin
                rd_mux = {{16{gear_num_r[15]}}, gear_num_r};
                bad_val = $signed(pwdata) > 32'(GEAR_NUM_MAX)
                    || $signed(pwdata) < -32'(GEAR_NUM_MAX);
            end
            OFF_GEAR_DEN: begin
                rd_mux = {16'h0, gear_den_r};
                bad_val = pwdata > 32'(GEAR_DEN_MAX) || pwdata < 32'(GEAR_DEN_MIN);
            end
            OFF_FILT_TC: begin
                rd_mux = {17'h0, filt_tc_r};
                bad_val = pwdata > 32'(FILT_TC_MAX);
            end
            OFF_DRIVE_CFG: rd_mux = {16'h0, drive_cfg_r};
            OFF_STATUS: rd_mux = {29'h0, dir_r, seen_r, fault_r};
            OFF_SPEED: rd_mux = filt_r;
            OFF_RAW_SPEED: rd_mux = raw_r;
            OFF_POSITION: rd_mux = pos_r;
            default: bad_addr = 1'b1;
        endcase
    end

    assign pslverr = access && (bad_addr || (pwrite && bad_val));

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            prdata_r <= 32'h0;
        end else if (setup) begin
            prdata_r <= rd_mux;
        end
    end

    // out-of-range values are refused and the old setting kept
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            mode_r <= MODE_RST;
            marks_r <= MARKS_RST;
            gear_num_r <= GEAR_NUM_RST;
            gear_den_r <= GEAR_DEN_RST;
            filt_tc_r <= FILT_TC_RST;
            drive_cfg_r <= DRIVE_CFG_RST;
        end else if (wr) begin
            unique case (paddr)
                OFF_MODE: mode_r <= pwdata[15:0];
                OFF_MARKS: marks_r <= pwdata[13:0];
                OFF_GEAR_NUM: gear_num_r <= pwdata[15:0];
                OFF_GEAR_DEN: gear_den_r <= pwdata[15:0];
                OFF_FILT_TC: filt_tc_r <= pwdata[14:0];
                OFF_DRIVE_CFG: drive_cfg_r <= pwdata[15:0];
                default: ;
            endcase
        end
    end

endmodule : incremental_encoder_speed_eval

// [verification/enc_eval_chk_sva.sv]
// checker: bus and sensor-result properties of the speed evaluator
`timescale 1ns/1ps
module enc_eval_chk
    import enc_pkg::*;
(
    // clock, reset and apb
    input wire logic clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // sensor and results
    input wire logic index_track_input,
    input wire logic signed [31:0] speed_out,
    input wire logic index_mark_pulse,
    input wire logic index_fault,
    input wire logic track_a_free,
    input wire logic track_b_free,
    input wire logic track_b_assigned
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    ////////////////////////////////////////
    ready_in_access_a: assert property (pready == (psel && penable))
        else $error("pready not tied to access phase");
    unmapped_refused_a: assert property (psel && penable && paddr > OFF_POSITION
        |-> pslverr && prdata == 32'h0) else $error("unmapped access not refused");
    marks_range_a: assert property (psel && penable && pwrite && paddr == OFF_MARKS
        && (pwdata == 32'h0 || pwdata > 32'h2000) |-> pslverr)
        else $error("bad mark count taken");
    off_frees_both_a: assert property (track_a_free |-> track_b_free)
        else $error("track b held while sensing is off");
    b_assign_a: assert property (track_b_assigned |-> track_a_free || !track_b_free)
        else $error("track b assigned to a mode that frees it");
    pulse_one_cycle_a: assert property (index_mark_pulse |=> !index_mark_pulse)
        else $error("index mark pulse too long");
    pulse_cause_a: assert property (index_mark_pulse
        |-> $past(index_track_input, 3) && !$past(index_track_input, 4))
        else $error("index mark pulse without synchronised index rise");
    fault_sticky_a: assert property (index_fault && !(psel && penable && pwrite
        && paddr == OFF_STATUS && pwdata[ST_FAULT]) |=> index_fault)
        else $error("index fault dropped without clear");
    fault_in_mode_a: assert property ($rose(index_fault) |-> !track_a_free)
        else $error("index fault raised while sensing is off");
    speed_once_a: assert property ($changed(speed_out) |=> $stable(speed_out) [*8])
        else $error("speed changed twice within a few cycles");
endmodule : enc_eval_chk

bind incremental_encoder_speed_eval enc_eval_chk i_chk (.clk, .reset, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .index_track_input, .speed_out,
    .index_mark_pulse, .index_fault, .track_a_free, .track_b_free, .track_b_assigned);

// [verification/enc_sensor_model.sv]
// sensor model: quadrature tracks or direction level, one index mark per turn
`timescale 1ns/1ps
module enc_sensor_model #(
    parameter int QUARTER_NS = 100,
    parameter int MARKS = 10
) (
    // direction and wiring
    input wire logic up,
    input wire logic quad,
    input wire logic dir_level,
    // sensor lines
    output logic track_a,
    output logic track_b,
    output logic index_out
);
    int ph = 0;
    int cnt = 0;
    logic a_old;
    ////////////////////////////////////////
    // timing scaled with the short window, so edges come far above the rated rate
    initial begin
        track_a = 1'b0;
        track_b = 1'b0;
        index_out = 1'b0;
        #1;
        forever begin
            #(QUARTER_NS);
            a_old = track_a;
            ph = up ? (ph + 1) % 4 : (ph + 3) % 4;
            track_a = ph == 1 || ph == 2;
            track_b = quad ? ph >= 2 : dir_level;
            cnt = (track_a && !a_old) ? cnt + 1 : cnt;
            index_out = cnt == MARKS;
            cnt = cnt % MARKS;
        end
    end
endmodule : enc_sensor_model

// [verification/tb_top.sv]
// testbench: registers, modes, gear, filter and index check of the speed evaluator
`timescale 1ns/1ps
module tb_top;
    import enc_pkg::*;
    logic clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rdv;
    logic pready, pslverr, track_a_input, track_b_or_direction_input, index_track_input;
    logic index_mark_pulse, index_fault, track_a_free, track_b_free, track_b_assigned, errv;
    logic signed [31:0] speed_out;
    logic up = 1'b1, quad = 1'b1, dir_level = 1'b0;
    int fail_count = 0, comparisons = 0, k;
    longint num = 100, den = 100, marks = 10;
    int mdl[logic [7:0]] = '{OFF_MODE: 0, OFF_MARKS: 1024, OFF_GEAR_NUM: 100,
        OFF_GEAR_DEN: 100, OFF_FILT_TC: 0, OFF_DRIVE_CFG: 0};
    int md[17] = '{1001, 1002, 1004, 1011, 1012, 1031, 1032, 1101, 1102, 1104, 1111, 1112,
        1131, 1132, 11, 12, 0};
    int cf[4] = '{0, 210, 211, 230};
    logic [7:0] ra[9] = '{OFF_MARKS, OFF_MARKS, OFF_MARKS, OFF_GEAR_NUM, OFF_GEAR_NUM,
        OFF_GEAR_DEN, OFF_FILT_TC, OFF_FILT_TC, 8'h28};
    logic [31:0] rv[9] = '{32'h0, 32'h2001, 32'h2000, 32'hffff8ad0, 32'h7531, 32'h0,
        32'h7d01, 32'h7d00, 32'h5};
    logic re[9] = '{1, 1, 0, 0, 1, 1, 1, 0, 1};

    always #2 clk = ~clk;

    // short window keeps each mode test to a few thousand cycles
    incremental_encoder_speed_eval #(.WINDOW_CYCLES(1000)) i_dut (.clk, .reset, .psel,
        .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .track_a_input,
        .track_b_or_direction_input, .index_track_input, .speed_out, .index_mark_pulse,
        .index_fault, .track_a_free, .track_b_free, .track_b_assigned);
    enc_sensor_model #(.MARKS(10)) i_enc (.up, .quad, .dir_level, .track_a(track_a_input),
        .track_b(track_b_or_direction_input), .index_out(index_track_input));
    ////////////////////////////////////////
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : report_and_stop

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            fail_count++;
            report_and_stop();
        end
        rdv = prdata;
        errv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic e);
        apb(1'b1, a, d);
        check("slave error", errv, e);
        if (!e && mdl.exists(a)) begin
            mdl[a] = d;
        end
    endtask : wr

    task automatic rd(input logic [7:0] a);
        apb(1'b0, a, 32'h0);
        check("read back", rdv, mdl.exists(a) ? mdl[a] : 0);
    endtask : rd

    // bench model: edges per window are 10 per evaluation step at this sensor rate
    function automatic logic [31:0] exp_speed(int m);
        int ev;
        longint s;
        if (m == 0) begin
            return 32'h0;
        end
        ev = (m % 100) % 10;
        s = (m % 100 < 10) ? (up ? 1 : -1) : (m % 100 > 30) ? (dir_level ? -1 : 1) : 1;
        s = ((m / 100) % 10 == 1) ? -s : s;
        return 32'(s * 10 * ev * 6000000 * num / (marks * ev * den));
    endfunction : exp_speed
    ////////////////////////////////////////
    initial begin
        rdv = $urandom(2856);
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        foreach (mdl[a]) begin
            rd(a);
        end
        $display("test reset values done");
        foreach (ra[i]) begin
            wr(ra[i], rv[i], re[i]);
            rd(ra[i]);
        end
        $display("test register ranges done");
        wr(OFF_FILT_TC, 32'h0, 1'b0);
        wr(OFF_GEAR_NUM, 32'h64, 1'b0);
        wr(OFF_MARKS, 32'ha, 1'b0);
        foreach (cf[i]) begin
            wr(OFF_DRIVE_CFG, cf[i], 1'b0);
            repeat (3) @(posedge clk);
            check("b assigned", track_b_assigned, cf[i] != 0);
        end
        $display("test drive configurations done");
        foreach (md[i]) begin
            up <= 1'($urandom);
            dir_level <= 1'($urandom);
            quad <= (md[i] % 100) < 10;
            k = md[i] % 100;
            wr(OFF_MODE, md[i], 1'b0);
            repeat (2000) @(posedge clk);
            // clear faults from the turn that straddled the mode change
            wr(OFF_STATUS, 32'h1, 1'b0);
            repeat (2000) @(posedge clk);
            check("speed", speed_out, exp_speed(md[i]));
            check("index fault", index_fault, 1'b0);
            check("a free", track_a_free, md[i] == 0);
            check("b free", track_b_free, md[i] == 0 || k == 11 || k == 12);
            check("b assigned", track_b_assigned, !(k == 11 || k == 12));
            $display("test mode %0d done", md[i]);
        end
        quad <= 1'b0;
        wr(OFF_MODE, 32'h3f3, 1'b0);
        wr(OFF_GEAR_NUM, 32'hffffff38, 1'b0);
        wr(OFF_GEAR_DEN, 32'h12c, 1'b0);
        num = -200;
        den = 300;
        repeat (4000) @(posedge clk);
        check("geared speed", speed_out, exp_speed(1011));
        $display("test gear done");
        wr(OFF_FILT_TC, 32'h7d00, 1'b0);
        wr(OFF_GEAR_NUM, 32'h64, 1'b0);
        wr(OFF_GEAR_DEN, 32'h64, 1'b0);
        repeat (3000) @(posedge clk);
        check("filter lag", speed_out > -4000000 && speed_out < 0, 1'b1);
        $display("test filter done");
        wr(OFF_FILT_TC, 32'h0, 1'b0);
        up <= 1'b1;
        quad <= 1'b1;
        wr(OFF_MODE, 32'h3e9, 1'b0);
        wr(OFF_MARKS, 32'h9, 1'b0);
        repeat (3000) @(posedge clk);
        check("index fault", index_fault, 1'b1);
        apb(1'b0, OFF_STATUS, 32'h0);
        check("status", rdv, 32'h3);
        $display("test index fault done");
        report_and_stop();
    end
endmodule : tb_top
